// File: logic/mrs_pkg.sv
// constants and state types of the reset sequencer
package mrs_pkg;

    // ----------------------------------------
    // vector locations
    // ----------------------------------------
    localparam logic [15:0] VEC_LO_ADDR = 16'hFFFC;
    localparam logic [15:0] VEC_HI_ADDR = 16'hFFFD;

    // ----------------------------------------
    // register address space
    // ----------------------------------------
    localparam int SFR_COUNT = 64;
    localparam int HI_COUNT = 10;
    localparam int PORT_COUNT = 7;
    localparam logic [11:0] HI_BASE_ADDR = 12'h0FF0;
    localparam logic [11:0] HI_LAST_ADDR = 12'h0FF9;
    localparam int PULLUP_BASE_IDX = 0;
    localparam int OWN_ADDR_BASE_IDX = 7;

    // ----------------------------------------
    // low register offsets
    // ----------------------------------------
    localparam logic [5:0] OFS_PORT0_DATA = 6'h00;
    localparam logic [5:0] OFS_PORT0_DIRECTION = 6'h01;
    localparam logic [5:0] OFS_TIMER_SOURCE_SELECT_A = 6'h0E;
    localparam logic [5:0] OFS_TIMER_SOURCE_SELECT_B = 6'h0F;
    localparam logic [5:0] OFS_STOP_RECOVERY = 6'h10;
    localparam logic [5:0] OFS_I2C_SHIFT = 6'h11;
    localparam logic [5:0] OFS_I2C_SPECIAL_STATUS = 6'h12;
    localparam logic [5:0] OFS_I2C_BUS_STATUS = 6'h13;
    localparam logic [5:0] OFS_I2C_BUS_CONTROL = 6'h14;
    localparam logic [5:0] OFS_I2C_CLOCK_CONTROL = 6'h15;
    localparam logic [5:0] OFS_I2C_CONDITION_CONTROL = 6'h16;
    localparam logic [5:0] OFS_I2C_SPECIAL_CONTROL = 6'h17;
    localparam logic [5:0] OFS_SERIAL1_BUFFER = 6'h18;
    localparam logic [5:0] OFS_SERIAL1_STATUS = 6'h19;
    localparam logic [5:0] OFS_SERIAL1_CONTROL = 6'h1A;
    localparam logic [5:0] OFS_ASYNC1_LINE_CONTROL = 6'h1B;
    localparam logic [5:0] OFS_BAUD1 = 6'h1C;
    localparam logic [5:0] OFS_WATCHDOG_CONTROL = 6'h1E;
    localparam logic [5:0] OFS_SERIAL2_DATA = 6'h1F;
    localparam logic [5:0] OFS_PRESCALER_12 = 6'h20;
    localparam logic [5:0] OFS_TIMER_ONE = 6'h21;
    localparam logic [5:0] OFS_TIMER_TWO = 6'h22;
    localparam logic [5:0] OFS_PRESCALER_X = 6'h24;
    localparam logic [5:0] OFS_TIMER_X = 6'h25;
    localparam logic [5:0] OFS_PRESCALER_Y = 6'h26;
    localparam logic [5:0] OFS_TIMER_Y = 6'h27;
    localparam logic [5:0] OFS_WIDE_TIMER_LOW_BYTE = 6'h28;
    localparam logic [5:0] OFS_WIDE_TIMER_HIGH_BYTE = 6'h29;
    localparam logic [5:0] OFS_PWM_PRESCALER = 6'h2C;
    localparam logic [5:0] OFS_PWM_PERIOD = 6'h2D;
    localparam logic [5:0] OFS_BAUD3 = 6'h2F;
    localparam logic [5:0] OFS_SERIAL3_BUFFER = 6'h30;
    localparam logic [5:0] OFS_SERIAL3_STATUS = 6'h31;
    localparam logic [5:0] OFS_ASYNC3_LINE_CONTROL = 6'h33;
    localparam logic [5:0] OFS_CONVERTER_CONTROL = 6'h34;
    localparam logic [5:0] OFS_CONVERSION_ONE = 6'h35;
    localparam logic [5:0] OFS_DAC_ONE = 6'h36;
    localparam logic [5:0] OFS_DAC_TWO = 6'h37;
    localparam logic [5:0] OFS_IRQ_SOURCE_SELECT = 6'h39;
    localparam logic [5:0] OFS_IRQ_EDGE_SELECT = 6'h3A;
    localparam logic [5:0] OFS_CPU_MODE_CONTROL = 6'h3B;
    localparam logic [5:0] OFS_IRQ_REQUEST_ONE = 6'h3C;
    localparam logic [5:0] OFS_IRQ_REQUEST_TWO = 6'h3D;
    localparam logic [5:0] OFS_IRQ_CONTROL_ONE = 6'h3E;
    localparam logic [5:0] OFS_IRQ_CONTROL_TWO = 6'h3F;

    // ----------------------------------------
    // values after reset
    // ----------------------------------------
    localparam logic [7:0] RST_CLEAR = 8'h00;
    localparam logic [7:0] RST_TIMER_SOURCE = 8'h33;
    localparam logic [7:0] RST_COUNT_FULL = 8'hFF;
    localparam logic [7:0] RST_TIMER_ONE = 8'h01;
    localparam logic [7:0] RST_WATCHDOG = 8'h3F;
    localparam logic [7:0] RST_I2C_CONDITION = 8'h1A;
    localparam logic [7:0] RST_I2C_SPECIAL_STATUS = 8'h20;
    localparam logic [7:0] RST_I2C_BUS_STATUS = 8'h10;
    localparam logic [7:0] RST_SERIAL_STATUS = 8'h80;
    localparam logic [7:0] RST_ASYNC_LINE = 8'hE0;
    localparam logic [7:0] RST_CONVERTER = 8'h04;
    localparam logic [7:0] RST_CPU_MODE = 8'h24;

    // registers with no defined value after reset
    localparam logic [63:0] UNDEF_MASK = 64'h0021_B000_9102_0000;

    // ----------------------------------------
    // state
    // ----------------------------------------
    typedef enum logic [2:0] {
        ST_HOLD = 3'b000,
        ST_REQ_LO = 3'b001,
        ST_WAIT_LO = 3'b010,
        ST_REQ_HI = 3'b011,
        ST_WAIT_HI = 3'b100,
        ST_RUN = 3'b101
    } mrs_phase_t;

    typedef struct packed {
        mrs_phase_t phase;
        logic vec_req;
        logic [15:0] vec_addr;
        logic [7:0] vec_lo;
        logic [15:0] pc;
        logic pc_load;
        logic run;
        logic [7:0] rd_data;
        logic rd_valid;
        logic [63:0][7:0] sfr;
        logic [9:0][7:0] hi;
    } mrs_state_t;

endpackage : mrs_pkg

// File: logic/mrs_rst_sync.sv
// reset synchroniser: asynchronous assertion, clocked release
`timescale 1ns/10ps
`default_nettype none
module mrs_rst_sync (
    // clock and raw reset pin
    input wire logic clk,
    input wire logic rst_n,
    // released reset
    output logic rst_sync_n
);
    logic meta_reg;
    logic sync_reg;

    // ----------------------------------------
    // two stages, only the second is read
    // ----------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_reg <= 1'b0;
            sync_reg <= 1'b0;
        end else begin
            meta_reg <= 1'b1;
            sync_reg <= meta_reg;
        end
    end

    assign rst_sync_n = sync_reg;
endmodule : mrs_rst_sync
`default_nettype wire

// File: logic/mrs_sequencer.sv
// reset sequencer: register reset values and reset vector fetch
`timescale 1ns/10ps
`default_nettype none
module mrs_sequencer #(
    parameter int PORT_COUNT = mrs_pkg::PORT_COUNT
) (
    // main oscillator clock and reset pin
    input wire logic clk,
    input wire logic rst_n,
    // vector fetch from program memory
    output logic vec_rd_req,
    output logic [15:0] vec_rd_addr,
    input wire logic vec_rd_valid,
    input wire logic [7:0] vec_rd_data,
    // cpu start
    output logic [15:0] pc_value,
    output logic pc_load,
    output logic cpu_run,
    // register write from the cpu
    input wire logic wr_en,
    input wire logic [11:0] wr_addr,
    input wire logic [7:0] wr_data,
    // register read from the cpu
    input wire logic rd_en,
    input wire logic [11:0] rd_addr,
    output logic [7:0] rd_data,
    output logic rd_valid,
    // port controls
    output logic [8*PORT_COUNT-1:0] port_out,
    output logic [8*PORT_COUNT-1:0] port_direction,
    output logic [8*PORT_COUNT-1:0] port_pullup
);
    // ----------------------------------------
    // elaboration check
    // ----------------------------------------
    // pull-up and port maps are laid out for this many ports
    if (PORT_COUNT != mrs_pkg::PORT_COUNT) begin : g_port_count_check
        $error("port count must match the register map");
    end

    // ----------------------------------------
    // address decode helpers
    // ----------------------------------------
    function automatic logic is_low(input logic [11:0] a);
        return a[11:6] == 6'h00;
    endfunction : is_low

    function automatic logic is_high(input logic [11:0] a);
        return a >= mrs_pkg::HI_BASE_ADDR && a <= mrs_pkg::HI_LAST_ADDR;
    endfunction : is_high

    function automatic logic [3:0] high_idx(input logic [11:0] a);
        logic [11:0] d;
        d = a - mrs_pkg::HI_BASE_ADDR;
        return d[3:0];
    endfunction : high_idx

    function automatic logic is_undef(input logic [11:0] a);
        return is_low(a) && mrs_pkg::UNDEF_MASK[a[5:0]];
    endfunction : is_undef

    // ----------------------------------------
    // reset image of the low register block
    // ----------------------------------------
    function automatic logic [63:0][7:0] sfr_image();
        logic [63:0][7:0] v;
        v = '0;
        // port latches and directions start as inputs
        for (int p = 0; p < mrs_pkg::PORT_COUNT; p++) begin
            v[mrs_pkg::OFS_PORT0_DATA + 2*p] = mrs_pkg::RST_CLEAR;
            v[mrs_pkg::OFS_PORT0_DIRECTION + 2*p] = mrs_pkg::RST_CLEAR;
        end

        // cleared control and interrupt registers
        v[mrs_pkg::OFS_STOP_RECOVERY] = mrs_pkg::RST_CLEAR;
        v[mrs_pkg::OFS_I2C_BUS_CONTROL] = mrs_pkg::RST_CLEAR;
        v[mrs_pkg::OFS_I2C_CLOCK_CONTROL] = mrs_pkg::RST_CLEAR;
        v[mrs_pkg::OFS_I2C_SPECIAL_CONTROL] = mrs_pkg::RST_CLEAR;
        v[mrs_pkg::OFS_SERIAL1_CONTROL] = mrs_pkg::RST_CLEAR;
        v[mrs_pkg::OFS_DAC_ONE] = mrs_pkg::RST_CLEAR;
        v[mrs_pkg::OFS_DAC_TWO] = mrs_pkg::RST_CLEAR;
        v[mrs_pkg::OFS_IRQ_SOURCE_SELECT] = mrs_pkg::RST_CLEAR;
        v[mrs_pkg::OFS_IRQ_EDGE_SELECT] = mrs_pkg::RST_CLEAR;
        v[mrs_pkg::OFS_IRQ_REQUEST_ONE] = mrs_pkg::RST_CLEAR;
        v[mrs_pkg::OFS_IRQ_REQUEST_TWO] = mrs_pkg::RST_CLEAR;
        v[mrs_pkg::OFS_IRQ_CONTROL_ONE] = mrs_pkg::RST_CLEAR;
        v[mrs_pkg::OFS_IRQ_CONTROL_TWO] = mrs_pkg::RST_CLEAR;

        // preset values
        v[mrs_pkg::OFS_TIMER_SOURCE_SELECT_A] = mrs_pkg::RST_TIMER_SOURCE;
        v[mrs_pkg::OFS_TIMER_SOURCE_SELECT_B] = mrs_pkg::RST_TIMER_SOURCE;
        v[mrs_pkg::OFS_I2C_SPECIAL_STATUS] = mrs_pkg::RST_I2C_SPECIAL_STATUS;
        v[mrs_pkg::OFS_I2C_BUS_STATUS] = mrs_pkg::RST_I2C_BUS_STATUS;
        v[mrs_pkg::OFS_I2C_CONDITION_CONTROL] = mrs_pkg::RST_I2C_CONDITION;
        v[mrs_pkg::OFS_SERIAL1_STATUS] = mrs_pkg::RST_SERIAL_STATUS;
        v[mrs_pkg::OFS_ASYNC1_LINE_CONTROL] = mrs_pkg::RST_ASYNC_LINE;
        v[mrs_pkg::OFS_WATCHDOG_CONTROL] = mrs_pkg::RST_WATCHDOG;
        v[mrs_pkg::OFS_PRESCALER_12] = mrs_pkg::RST_COUNT_FULL;
        v[mrs_pkg::OFS_TIMER_ONE] = mrs_pkg::RST_TIMER_ONE;
        v[mrs_pkg::OFS_TIMER_TWO] = mrs_pkg::RST_COUNT_FULL;
        v[mrs_pkg::OFS_PRESCALER_X] = mrs_pkg::RST_COUNT_FULL;
        v[mrs_pkg::OFS_TIMER_X] = mrs_pkg::RST_COUNT_FULL;
        v[mrs_pkg::OFS_PRESCALER_Y] = mrs_pkg::RST_COUNT_FULL;
        v[mrs_pkg::OFS_TIMER_Y] = mrs_pkg::RST_COUNT_FULL;
        v[mrs_pkg::OFS_WIDE_TIMER_LOW_BYTE] = mrs_pkg::RST_COUNT_FULL;
        v[mrs_pkg::OFS_WIDE_TIMER_HIGH_BYTE] = mrs_pkg::RST_COUNT_FULL;
        v[mrs_pkg::OFS_SERIAL3_STATUS] = mrs_pkg::RST_SERIAL_STATUS;
        v[mrs_pkg::OFS_ASYNC3_LINE_CONTROL] = mrs_pkg::RST_ASYNC_LINE;
        v[mrs_pkg::OFS_CONVERTER_CONTROL] = mrs_pkg::RST_CONVERTER;
        v[mrs_pkg::OFS_CPU_MODE_CONTROL] = mrs_pkg::RST_CPU_MODE;
        return v;
    endfunction : sfr_image

    localparam logic [63:0][7:0] SFR_RESET = sfr_image();

    // ----------------------------------------
    // reset image of the high register block
    // ----------------------------------------
    function automatic logic [9:0][7:0] hi_image();
        logic [9:0][7:0] v;
        v = '0;
        for (int p = 0; p < mrs_pkg::PORT_COUNT; p++) begin
            v[mrs_pkg::PULLUP_BASE_IDX + p] = mrs_pkg::RST_CLEAR;
        end
        for (int i = mrs_pkg::OWN_ADDR_BASE_IDX; i < mrs_pkg::HI_COUNT;
                i++) begin
            v[i] = mrs_pkg::RST_CLEAR;
        end
        return v;
    endfunction : hi_image

    localparam logic [9:0][7:0] HI_RESET = hi_image();

    // ----------------------------------------
    // reset release
    // ----------------------------------------
    // the pin is only trusted to meet its minimum low time; a short
    // glitch still clears every register but the unreset buffers, which is the safe side
    logic rst_sync_n;

    mrs_rst_sync u_rst_sync (
        .clk(clk),
        .rst_n(rst_n),
        .rst_sync_n(rst_sync_n)
    );

    // ----------------------------------------
    // state
    // ----------------------------------------
    mrs_pkg::mrs_state_t state_reg;
    mrs_pkg::mrs_state_t state_next;
    // buffers and shift registers keep no reset value
    logic [7:0] undef_mem [0:63];
    logic undef_wr;
    logic [5:0] low_wr_idx;
    logic [5:0] low_rd_idx;
    logic [3:0] hi_wr_idx;
    logic [3:0] hi_rd_idx;

    assign low_wr_idx = wr_addr[5:0];
    assign low_rd_idx = rd_addr[5:0];
    assign hi_wr_idx = high_idx(wr_addr);
    assign hi_rd_idx = high_idx(rd_addr);

    // writes only land once the cpu runs
    assign undef_wr = state_reg.run && wr_en
        && is_undef(wr_addr);

    // ----------------------------------------
    // phase machine and register file
    // ----------------------------------------
    always_comb begin
        state_next = state_reg;
        state_next.vec_req = 1'b0;
        state_next.pc_load = 1'b0;
        state_next.rd_valid = 1'b0;
        case (state_reg.phase)
            mrs_pkg::ST_HOLD: begin
                // first edge after a clean release
                state_next.phase = mrs_pkg::ST_REQ_LO;
            end
            mrs_pkg::ST_REQ_LO: begin
                state_next.vec_req = 1'b1;
                state_next.vec_addr = mrs_pkg::VEC_LO_ADDR;
                state_next.phase = mrs_pkg::ST_WAIT_LO;
            end
            mrs_pkg::ST_WAIT_LO: begin
                // no timeout: a silent memory keeps the cpu held
                if (vec_rd_valid) begin
                    state_next.vec_lo = vec_rd_data;
                    state_next.phase = mrs_pkg::ST_REQ_HI;
                end
            end
            mrs_pkg::ST_REQ_HI: begin
                state_next.vec_req = 1'b1;
                state_next.vec_addr = mrs_pkg::VEC_HI_ADDR;
                state_next.phase = mrs_pkg::ST_WAIT_HI;
            end
            mrs_pkg::ST_WAIT_HI: begin
                if (vec_rd_valid) begin
                    state_next.pc = {vec_rd_data, state_reg.vec_lo};
                    state_next.pc_load = 1'b1;
                    state_next.run = 1'b1;
                    state_next.phase = mrs_pkg::ST_RUN;
                end
            end
            mrs_pkg::ST_RUN: begin
                // a same-edge read still sees the old value
                if (wr_en && is_low(wr_addr)
                        && !is_undef(wr_addr)) begin
                    state_next.sfr[low_wr_idx] = wr_data;
                end else if (wr_en && is_high(wr_addr)) begin
                    state_next.hi[hi_wr_idx] = wr_data;
                end
                if (rd_en) begin
                    state_next.rd_valid = 1'b1;
                    if (is_low(rd_addr)) begin
                        if (is_undef(rd_addr)) begin
                            state_next.rd_data = undef_mem[low_rd_idx];
                        end else begin
                            state_next.rd_data = state_reg.sfr[low_rd_idx];
                        end
                    end else if (is_high(rd_addr)) begin
                        state_next.rd_data = state_reg.hi[hi_rd_idx];
                    end else begin
                        // unmapped space reads as zero
                        state_next.rd_data = 8'h00;
                    end
                end
            end
            default: begin
                state_next.phase = mrs_pkg::ST_HOLD;
            end
        endcase
    end

    // ----------------------------------------
    // registers
    // ----------------------------------------
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            state_reg.phase <= mrs_pkg::ST_HOLD;
            state_reg.vec_req <= 1'b0;
            state_reg.vec_addr <= 16'h0000;
            state_reg.vec_lo <= 8'h00;
            state_reg.pc <= 16'h0000;
            state_reg.pc_load <= 1'b0;
            state_reg.run <= 1'b0;
            state_reg.rd_data <= 8'h00;
            state_reg.rd_valid <= 1'b0;
            state_reg.sfr <= SFR_RESET;
            state_reg.hi <= HI_RESET;
        end else begin
            state_reg <= state_next;
        end
    end

    // no reset: contents are garbage until software writes them
    always_ff @(posedge clk) begin
        if (undef_wr) begin
            undef_mem[low_wr_idx] <= wr_data;
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign vec_rd_req = state_reg.vec_req;
    assign vec_rd_addr = state_reg.vec_addr;
    assign pc_value = state_reg.pc;
    assign pc_load = state_reg.pc_load;
    assign cpu_run = state_reg.run;
    assign rd_data = state_reg.rd_data;
    assign rd_valid = state_reg.rd_valid;

    for (genvar p = 0; p < PORT_COUNT; p++) begin : g_port
        assign port_out[8*p +: 8] = state_reg.sfr[2*p];
        assign port_direction[8*p +: 8] = state_reg.sfr[2*p + 1];
        assign port_pullup[8*p +: 8] =
            state_reg.hi[mrs_pkg::PULLUP_BASE_IDX + p];
    end

endmodule : mrs_sequencer
`default_nettype wire

// File: test/mrs_vec_mem.sv
// program memory model answering the reset vector fetch
`timescale 1ns/10ps
`default_nettype none
module mrs_vec_mem (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // vector fetch
    input wire logic vec_rd_req,
    input wire logic [15:0] vec_rd_addr,
    output logic vec_rd_valid,
    output logic [7:0] vec_rd_data,
    // stored vector and answer delay
    input wire logic [7:0] lo_byte,
    input wire logic [7:0] hi_byte,
    input wire logic [3:0] wait_cycles
);
    logic busy;
    logic [3:0] cnt;
    logic [7:0] byte_q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            busy <= 1'b0;
            cnt <= 4'h0;
            byte_q <= 8'h00;
            vec_rd_valid <= 1'b0;
            vec_rd_data <= 8'h5A;
        end else begin
            vec_rd_valid <= 1'b0;
            // released line: inverts every cycle, so the last byte shows every other cycle
            vec_rd_data <= ~vec_rd_data;
            if (vec_rd_req) begin
                busy <= 1'b1;
                cnt <= wait_cycles;
                byte_q <= (vec_rd_addr == 16'hFFFD) ? hi_byte : lo_byte;
            end else if (busy && cnt != 4'h0) begin
                cnt <= cnt - 4'h1;
            end else if (busy) begin
                busy <= 1'b0;
                vec_rd_valid <= 1'b1;
                vec_rd_data <= byte_q;
            end
        end
    end
endmodule : mrs_vec_mem
`default_nettype wire

// File: test/mrs_sequencer_chk.sv
// assertions on the reset sequencer ports
`timescale 1ns/10ps
`default_nettype none
module mrs_sequencer_chk #(
    parameter int PORT_COUNT = 7
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // watched signals
    input wire logic vec_rd_req,
    input wire logic [15:0] vec_rd_addr,
    input wire logic vec_rd_valid,
    input wire logic [7:0] vec_rd_data,
    input wire logic [15:0] pc_value,
    input wire logic pc_load,
    input wire logic cpu_run,
    input wire logic rd_en,
    input wire logic rd_valid,
    input wire logic [8*PORT_COUNT-1:0] port_out,
    input wire logic [8*PORT_COUNT-1:0] port_direction,
    input wire logic [8*PORT_COUNT-1:0] port_pullup
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    // ----------------------------------------
    // fetch steps
    // ----------------------------------------
    sequence lo_taken;
        vec_rd_valid && vec_rd_addr == 16'hFFFC && !cpu_run;
    endsequence
    sequence hi_taken;
        vec_rd_valid && vec_rd_addr == 16'hFFFD && !cpu_run;
    endsequence
    a_reset_ports: assert property ($rose(rst_n) |->
        port_out == '0 && port_direction == '0 && port_pullup == '0 && !cpu_run)
        else $error("ports not cleared by reset");
    a_first_fetch: assert property ($rose(rst_n) |->
        !vec_rd_req ##[1:4] (vec_rd_req && vec_rd_addr == 16'hFFFC))
        else $error("low vector byte not requested");
    a_lo_then_hi: assert property (lo_taken |=>
        ##[0:1] (vec_rd_req && vec_rd_addr == 16'hFFFD))
        else $error("high vector byte not requested");
    a_pc_from_hi: assert property (hi_taken |=>
        pc_load && cpu_run && pc_value[15:8] == $past(vec_rd_data))
        else $error("pc not loaded from high byte");
    a_run_with_load: assert property ($rose(cpu_run) |-> pc_load)
        else $error("run without pc load");
    a_run_stays: assert property (cpu_run |=> cpu_run && !pc_load)
        else $error("run dropped or pc reloaded");
    a_no_fetch_run: assert property (cpu_run |-> !vec_rd_req)
        else $error("vector fetch while running");
    a_read_latency: assert property (rd_valid == $past(rd_en && cpu_run))
        else $error("read answer timing wrong");
endmodule : mrs_sequencer_chk
`default_nettype wire

bind mrs_sequencer mrs_sequencer_chk #(.PORT_COUNT(PORT_COUNT)) u_chk (
    .clk, .rst_n, .vec_rd_req, .vec_rd_addr, .vec_rd_valid, .vec_rd_data,
    .pc_value, .pc_load, .cpu_run, .rd_en, .rd_valid, .port_out,
    .port_direction, .port_pullup);

// File: test/mrs_sequencer_test.sv
// self-checking bench of the reset sequencer
`timescale 1ns/10ps
`default_nettype none
module mrs_sequencer_test;
    logic clk, rst_n, wr_en, rd_en, rd_valid, pc_load, cpu_run;
    logic vec_rd_req, vec_rd_valid;
    logic [15:0] vec_rd_addr, pc_value;
    logic [7:0] vec_rd_data, wr_data, rd_data, lo_byte, hi_byte, d;
    logic [11:0] wr_addr, rd_addr;
    logic [55:0] port_out, port_direction, port_pullup;
    logic [3:0] wait_cycles;
    logic [15:0] exp_q[$];
    logic [31:0] rnd = 32'h0000_E924;
    // no defined value after reset, skipped in the reset-value reads
    logic [63:0] undef_map = 64'h0021_B000_9102_0000;
    int err_total = 0;
    int check_count = 0;
    int cycles = 0;

    mrs_sequencer u_mrs_sequencer (.clk, .rst_n, .vec_rd_req, .vec_rd_addr,
        .vec_rd_valid, .vec_rd_data, .pc_value, .pc_load, .cpu_run, .wr_en,
        .wr_addr, .wr_data, .rd_en, .rd_addr, .rd_data, .rd_valid, .port_out,
        .port_direction, .port_pullup);
    mrs_vec_mem u_mrs_vec_mem (.clk, .rst_n, .vec_rd_req, .vec_rd_addr,
        .vec_rd_valid, .vec_rd_data, .lo_byte, .hi_byte, .wait_cycles);

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    function automatic logic [7:0] next_rnd();
        rnd ^= rnd << 13;
        rnd ^= rnd >> 17;
        rnd ^= rnd << 5;
        return rnd[7:0];
    endfunction : next_rnd

    function automatic logic [7:0] rst_val(input logic [11:0] a);
        case (a)
            12'h00E, 12'h00F: return 8'h33;
            12'h012: return 8'h20;
            12'h013: return 8'h10;
            12'h016: return 8'h1A;
            12'h019, 12'h031: return 8'h80;
            12'h01B, 12'h033: return 8'hE0;
            12'h01E: return 8'h3F;
            12'h020, 12'h022, 12'h024, 12'h025, 12'h026, 12'h027,
            12'h028, 12'h029: return 8'hFF;
            12'h021: return 8'h01;
            12'h034: return 8'h04;
            12'h03B: return 8'h24;
            default: return 8'h00;
        endcase
    endfunction : rst_val

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic stop_test();
        $display("mismatches %0d of %0d checks", err_total, check_count);
        if (err_total == 0 && check_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : stop_test

    // reset low for at least sixteen oscillator cycles, then released
    task automatic do_reset(input int hold);
        @(posedge clk);
        rst_n <= 1'b0;
        @(negedge clk);
        check({8'h00, port_out[7:0]}, 16'h0000);
        repeat (hold) @(posedge clk);
        rst_n <= 1'b1;
    endtask : do_reset

    task automatic rd(input logic [11:0] a, input logic [7:0] exp);
        @(posedge clk);
        rd_en <= 1'b1;
        rd_addr <= a;
        exp_q.push_back({8'h00, exp});
        @(posedge clk);
        rd_en <= 1'b0;
    endtask : rd

    task automatic wr(input logic [11:0] a, input logic [7:0] v);
        @(posedge clk);
        wr_en <= 1'b1;
        wr_addr <= a;
        wr_data <= v;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask : wr

    // results are matched to the oldest note
    always @(posedge clk) begin
        if (pc_load === 1'b1 || rd_valid === 1'b1) begin
            if (exp_q.size() == 0) begin
                check(16'hDEAD, 16'h0000);
            end else if (pc_load === 1'b1) begin
                check(pc_value, exp_q.pop_front());
            end else begin
                check({8'h00, rd_data}, exp_q.pop_front());
            end
        end
    end

    always @(posedge clk) begin
        cycles++;
        if (cycles == 6000) begin
            err_total++;
            stop_test();
        end
    end

    initial begin
        int n;
        rst_n = 1'b0;
        {wr_en, rd_en, wr_addr, rd_addr, wr_data} = '0;
        {lo_byte, hi_byte, wait_cycles} = '0;
        // second pass resets mid-run, after writes, with a slow memory
        for (int pass = 0; pass < 2; pass++) begin
            lo_byte <= next_rnd();
            hi_byte <= next_rnd();
            wait_cycles <= pass ? 4'h7 : 4'h0;
            do_reset(16 + 7 * pass);
            exp_q.push_back({hi_byte, lo_byte});
            wr(12'h000, 8'hA5);
            n = 0;
            while (cpu_run !== 1'b1 && n < 100) begin
                @(posedge clk);
                n++;
            end
            check({8'h00, port_out[7:0]}, 16'h0000);
            for (int a = 0; a < 64; a++) begin
                if (!undef_map[a]) rd(12'(a), rst_val(12'(a)));
            end
            for (int a = 0; a < 10; a++) rd(12'hFF0 + 12'(a), 8'h00);
            // unreset storage holds what software wrote
            d = next_rnd();
            wr(12'h018, d);
            rd(12'h018, d);
            for (int p = 0; p < 7; p++) begin
                d = next_rnd();
                wr(12'(2 * p), d);
                wr(12'(2 * p + 1), ~d);
                wr(12'hFF0 + 12'(p), d ^ 8'h3C);
                @(posedge clk);
                check({8'h00, port_out[8*p+:8]}, {8'h00, d});
                check({8'h00, port_direction[8*p+:8]}, {8'h00, ~d});
                check({8'h00, port_pullup[8*p+:8]}, {8'h00, d ^ 8'h3C});
            end
        end
        repeat (3) @(posedge clk);
        check(16'(exp_q.size()), 16'h0000);
        stop_test();
    end
endmodule : mrs_sequencer_test
`default_nettype wire
